// [vdpra_top.sv]
// Shared-memory arbiter, VME A24 slave, mailboxes, SYSFAIL, irq, watchdog
// Behaviour
// - Local processor wins the shared memory over the VME port.
// - Local processor accesses are never stalled; no wait states.
// - VME access runs in a free local cycle on the local clock.
// - DMA engine reaches shared memory when the processor is idle; a colliding DMA access is dropped.
// - VME port decodes A24, D8/D16, jumper base in 128 Kbyte steps.
// - VME sees 16-bit memory with byte and word access.
// - VME access to reset mailbox resets processor and local devices.
// - VME SYSRESET* resets processor and on-board devices.
// - VME access to interrupt mailbox interrupts the local processor.
// - Mailbox interrupt leaves on the parallel/timer handshake input.
// - SYSFAIL* driven from reset until initialisation is done.
// - Software bit drives SYSFAIL* on detected on-board failure.
// - Four interrupt channels, each level 1 to 7 and a vector.
// - Local side triggers channels; level and vector are programmable.
// - Watchdog flags missing processor and DMA activity once software enables it.
// - Four-bit front-panel switch readable by local software.
// - Four-bit interface module code readable by local software.
// - Periodic timer tick interrupts the local processor.
// - Reserved low area stays reachable from the VME port.
`timescale 1ns/1ns
`default_nettype none
module vdpra_top #(
	parameter int WDG_CYCLES = vdpra_pkg::WDG_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic [1:0]  cpu_be,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [15:0] cpu_wdata,
	input  wire logic        dma_req,
	input  wire logic        dma_we,
	input  wire logic [1:0]  dma_be,
	input  wire logic [15:0] dma_addr,
	input  wire logic [15:0] dma_wdata,
	output var  logic [15:0] local_rdata,
	input  wire logic        vme_as_n,
	input  wire logic        vme_ds0_n,
	input  wire logic        vme_ds1_n,
	input  wire logic        vme_write_n,
	input  wire logic [5:0]  vme_am,
	input  wire logic [23:1] vme_addr,
	input  wire logic [15:0] vme_data_i,
	output var  logic [15:0] vme_data_o,
	output var  logic        vme_data_oe,
	output var  logic        vme_dtack_oe,
	input  wire logic        vme_sysreset_n,
	output var  logic        vme_sysfail_oe,
	output var  logic [7:1]  vme_irq_oe,
	output var  logic [7:0]  irq_vector,
	input  wire logic [6:0]  jmp_base,
	input  wire logic [5:0]  jmp_am,
	input  wire logic [3:0]  panel_switch,
	input  wire logic [3:0]  module_code,
	output var  logic        board_reset_n,
	output var  logic        pit_mbx_hs,
	output var  logic        pit_tick,
	output var  logic        wdg_fault
);
	import vdpra_pkg::*;

	localparam int WDW = $clog2(WDG_CYCLES + 1);
	localparam int SW  = 71;

	function automatic logic word_is(input logic [15:0] a,
	                                 input logic [15:0] t);
		word_is = (a == t);
	endfunction

	// Synchronised pins, active-low ones inverted ahead of the sync
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] pin_s;
	logic          as_s, ds0_s, ds1_s, wr_s, sysrst_s;
	logic [5:0]    am_s, jam_s;
	logic [23:1]   addr_s;
	logic [15:0]   vdat_s;
	logic [6:0]    jbase_s;
	logic [3:0]    sw_s, mod_s;

	assign pin_raw = {~vme_as_n, ~vme_ds0_n, ~vme_ds1_n, ~vme_write_n,
	                  ~vme_sysreset_n, vme_am, jmp_am, vme_addr,
	                  vme_data_i, jmp_base, panel_switch, module_code};

	vdpra_sync #(.W(SW)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pin_raw),
		.q       (pin_s)
	);

	assign {as_s, ds0_s, ds1_s, wr_s, sysrst_s, am_s, jam_s, addr_s,
	        vdat_s, jbase_s, sw_s, mod_s} = pin_s;

	// Registers and state
	vdpra_vst_t  vst_r, vst_nxt;
	logic [15:0] v_addr_r;
	logic [15:0] v_wdata_r;
	logic [1:0]  v_be_r;
	logic        v_we_r;
	logic [15:0] vme_data_r;
	logic        vme_data_oe_r, vme_dtack_oe_r;
	logic [2:0]  ctrl_r;
	logic [23:0] tick_per_r, tick_cnt_r;
	logic        tick_r;
	logic        mbx_r, wdg_r, coll_r;
	logic [WDW-1:0] wdg_cnt_r;
	logic [7:0]  brst_cnt_r;
	logic        brst_n_r;
	logic        sysfail_oe_r;
	logic [IRQ_CH-1:0] pend_r;
	logic [2:0]  lvl_r [IRQ_CH];
	logic [7:0]  vec_r [IRQ_CH];
	logic [7:1]  irq_oe_r;
	logic [7:0]  bvec_r;
	logic [31:0] prdata_r;
	logic        pready_r, pslverr_r;

	// Local arbitration: processor, then DMA, then VME in a free slot
	logic        loc_req, vme_go, mem_en, mem_we;
	logic [1:0]  mem_be;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	logic        vme_hit, ds_any, brst_trig, mbx_set;

	assign loc_req = cpu_req | dma_req;
	assign vme_go  = (vst_r == V_SLOT) && !loc_req;
	assign mem_en  = loc_req | vme_go;

	// Address and data mux; local never waits for the VME side
	always_comb begin
		if (cpu_req) begin
			mem_we    = cpu_we;
			mem_be    = cpu_be;
			mem_addr  = cpu_addr;
			mem_wdata = cpu_wdata;
		end else if (dma_req) begin
			mem_we    = dma_we;
			mem_be    = dma_be;
			mem_addr  = dma_addr;
			mem_wdata = dma_wdata;
		end else begin
			mem_we    = v_we_r;
			mem_be    = v_be_r;
			mem_addr  = v_addr_r;
			mem_wdata = v_wdata_r;
		end
	end

	vdpra_mem #(.AW(MEM_AW), .DW(MEM_DW)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (mem_en),
		.we      (mem_we),
		.be      (mem_be),
		.addr    (mem_addr),
		.wdata   (mem_wdata),
		.rdata   (mem_rdata)
	);
	assign local_rdata = mem_rdata;

	// A24 decode against jumpers; base compare covers A23..A17
	assign ds_any  = ds0_s | ds1_s;
	assign vme_hit = as_s && ds_any && (am_s == jam_s) &&
	                 (addr_s[23:17] == jbase_s);
	assign mbx_set = (vst_r == V_IDLE) && vme_hit &&
	                 word_is(addr_s[16:1], MBX_IRQ_WADDR);
	assign brst_trig = (vst_r == V_IDLE) && vme_hit &&
	                   word_is(addr_s[16:1], MBX_RESET_WADDR);

	// Slave port sequencing
	always_comb begin
		case (vst_r)
			V_IDLE: vst_nxt = vme_hit ? V_SLOT : V_IDLE;
			V_SLOT: begin
				if (!vme_go)
					vst_nxt = V_SLOT;
				else
					vst_nxt = v_we_r ? V_ACK : V_READ;
			end
			V_READ: vst_nxt = V_ACK;
			V_ACK:  vst_nxt = ds_any ? V_ACK : V_IDLE;
			default: vst_nxt = V_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vst_r <= V_IDLE;
		else
			vst_r <= vst_nxt;
	end

	// Latch the VME request; whole window reachable incl. low area
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v_addr_r  <= 16'h0000;
			v_wdata_r <= 16'h0000;
			v_be_r    <= 2'h0;
			v_we_r    <= 1'b0;
		end else if (vst_r == V_IDLE && vme_hit) begin
			v_addr_r  <= addr_s[16:1];
			v_wdata_r <= vdat_s;
			v_be_r    <= {ds1_s, ds0_s};
			v_we_r    <= wr_s;
		end
	end

	// Acknowledge and read data; held until both strobes drop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vme_data_r     <= 16'h0000;
			vme_data_oe_r  <= 1'b0;
			vme_dtack_oe_r <= 1'b0;
		end else begin
			if (vst_r == V_READ)
				vme_data_r <= mem_rdata;
			vme_dtack_oe_r <= (vst_nxt == V_ACK);
			vme_data_oe_r  <= (vst_nxt == V_ACK) && !v_we_r;
		end
	end

	// Board reset pulse from SYSRESET* or the reset mailbox
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brst_cnt_r <= 8'h00;
			brst_n_r   <= 1'b0;
		end else begin
			if (brst_trig)
				brst_cnt_r <= 8'(BRST_CYC);
			else if (brst_cnt_r != 8'h00)
				brst_cnt_r <= brst_cnt_r - 8'h01;
			brst_n_r <= !(sysrst_s || brst_trig ||
			              brst_cnt_r > 8'h01);
		end
	end

	// APB access decode
	logic        apb_setup, apb_wr;
	logic [31:0] rd_nxt;
	logic        err_nxt;
	logic [IRQ_CH-1:0] ch_sel;

	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pready_r && pwrite;

	always_comb begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		ch_sel  = '0;
		case (paddr)
			A_CTRL: rd_nxt[2:0] = ctrl_r;
			A_STAT: begin
				rd_nxt[STAT_SW +: 4]  = sw_s;
				rd_nxt[STAT_MOD +: 4] = mod_s;
				rd_nxt[STAT_MBX]      = mbx_r;
				rd_nxt[STAT_WDG]      = wdg_r;
				rd_nxt[STAT_COLL]     = coll_r;
				rd_nxt[STAT_SFAIL]    = sysfail_oe_r;
			end
			A_TICK:   rd_nxt[23:0] = tick_per_r;
			A_BIMCTL: rd_nxt[IRQ_CH-1:0] = pend_r;
			default: begin
				err_nxt = 1'b1;
				for (int c = 0; c < IRQ_CH; c++) begin
					if (paddr == A_BIMCH0 + 12'(4 * c)) begin
						ch_sel[c]      = 1'b1;
						err_nxt        = 1'b0;
						rd_nxt[2:0]    = lvl_r[c];
						rd_nxt[CH_VEC +: 8] = vec_r[c];
					end
				end
			end
		endcase
	end

	// One access cycle: ready in the first access phase cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= apb_setup;
			pslverr_r <= apb_setup && err_nxt;
			prdata_r  <= (apb_setup && !pwrite) ? rd_nxt : 32'h0000_0000;
		end
	end

	// Control; board reset drops init so SYSFAIL* returns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= CTRL_RST;
			tick_per_r <= TICK_RST;
		end else begin
			if (!brst_n_r)
				ctrl_r <= CTRL_RST;
			else if (apb_wr && paddr == A_CTRL)
				ctrl_r <= pwdata[2:0];
			if (apb_wr && paddr == A_TICK)
				tick_per_r <= pwdata[23:0];
		end
	end

	// SYSFAIL* until init, or while software reports a failure
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sysfail_oe_r <= 1'b1;
		else
			sysfail_oe_r <= !ctrl_r[CTRL_INIT] ||
			                ctrl_r[CTRL_FAIL];
	end

	// Sticky status flags; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mbx_r  <= 1'b0;
			coll_r <= 1'b0;
		end else begin
			if (mbx_set)
				mbx_r <= 1'b1;
			else if (apb_wr && paddr == A_STAT && pwdata[STAT_MBX])
				mbx_r <= 1'b0;
			if (cpu_req && dma_req)
				coll_r <= 1'b1;
			else if (apb_wr && paddr == A_STAT && pwdata[STAT_COLL])
				coll_r <= 1'b0;
		end
	end

	// Watchdog counts idle local cycles while software keeps CTRL_WDGEN set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdg_cnt_r <= '0;
			wdg_r     <= 1'b0;
		end else begin
			if (!ctrl_r[CTRL_WDGEN] || loc_req)
				wdg_cnt_r <= '0;
			else if (wdg_cnt_r == WDW'(WDG_CYCLES - 1))
				wdg_cnt_r <= '0;
			else
				wdg_cnt_r <= wdg_cnt_r + WDW'(1);
			if (ctrl_r[CTRL_WDGEN] && !loc_req &&
			    wdg_cnt_r == WDW'(WDG_CYCLES - 1))
				wdg_r <= 1'b1;
			else if (apb_wr && paddr == A_STAT && pwdata[STAT_WDG])
				wdg_r <= 1'b0;
		end
	end

	// Periodic scheduling tick, one cycle wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 24'h000000;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r + 24'h000001 >= tick_per_r) begin
			tick_cnt_r <= 24'h000000;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 24'h000001;
			tick_r     <= 1'b0;
		end
	end

	// Interrupt channels: pending set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= '0;
			for (int c = 0; c < IRQ_CH; c++) begin
				lvl_r[c] <= 3'h0;
				vec_r[c] <= VEC_RST;
			end
		end else begin
			for (int c = 0; c < IRQ_CH; c++) begin
				if (apb_wr && paddr == A_BIMCTL && pwdata[c])
					pend_r[c] <= 1'b1;
				else if (!brst_n_r ||
				         (apb_wr && paddr == A_BIMCTL &&
				          pwdata[CH_CLR + c]))
					pend_r[c] <= 1'b0;
				if (apb_wr && ch_sel[c]) begin
					lvl_r[c] <= pwdata[2:0];
					vec_r[c] <= pwdata[CH_VEC +: 8];
				end
			end
		end
	end

	// Level 0 disables a channel; lowest pending channel gives vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_oe_r <= 7'h00;
			bvec_r   <= 8'h00;
		end else begin
			for (int l = 1; l < 8; l++) begin
				irq_oe_r[l] <= 1'b0;
				for (int c = 0; c < IRQ_CH; c++) begin
					if (pend_r[c] && lvl_r[c] == 3'(l))
						irq_oe_r[l] <= 1'b1;
				end
			end
			bvec_r <= 8'h00;
			for (int c = IRQ_CH - 1; c >= 0; c--) begin
				if (pend_r[c] && lvl_r[c] != 3'h0)
					bvec_r <= vec_r[c];
			end
		end
	end

	// Outputs straight from flops
	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign vme_data_o     = vme_data_r;
	assign vme_data_oe    = vme_data_oe_r;
	assign vme_dtack_oe   = vme_dtack_oe_r;
	assign vme_sysfail_oe = sysfail_oe_r;
	assign vme_irq_oe     = irq_oe_r;
	assign irq_vector     = bvec_r;
	assign board_reset_n  = brst_n_r;
	assign pit_mbx_hs     = mbx_r;
	assign pit_tick       = tick_r;
	assign wdg_fault      = wdg_r;
endmodule // vdpra_top
`default_nettype wire

// [vdpra_pkg.sv]
// Shared constants and types of the VME shared-memory arbiter
`default_nettype none
package vdpra_pkg;
	// Clock and memory geometry
	localparam int CLK_HZ = 25_000_000;
	localparam int MEM_AW = 16;
	localparam int MEM_DW = 16;
	localparam int IRQ_CH = 4;
	// Word addresses of the two mailbox locations in the reserved low area
	localparam logic [15:0] MBX_RESET_WADDR = 16'h0002;
	localparam logic [15:0] MBX_IRQ_WADDR   = 16'h0003;
	// APB register byte offsets
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_STAT   = 12'h004;
	localparam logic [11:0] A_TICK   = 12'h008;
	localparam logic [11:0] A_BIMCTL = 12'h00C;
	localparam logic [11:0] A_BIMCH0 = 12'h010;
	// Field positions
	localparam int CTRL_INIT   = 0;
	localparam int CTRL_FAIL   = 1;
	localparam int CTRL_WDGEN  = 2;
	localparam int STAT_SW     = 0;
	localparam int STAT_MOD    = 4;
	localparam int STAT_MBX    = 8;
	localparam int STAT_WDG    = 9;
	localparam int STAT_COLL   = 10;
	localparam int STAT_SFAIL  = 11;
	localparam int CH_CLR      = 4;
	localparam int CH_VEC      = 8;
	// Reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [7:0] VEC_RST  = 8'h0F;
	// Timing: times in their own units, cycles derived from the clock
	localparam int TICK_PERIOD_US = 1000;
	localparam logic [23:0] TICK_RST =
		24'(TICK_PERIOD_US * (CLK_HZ / 1_000_000));
	localparam int BRST_PULSE_NS = 1000;
	localparam int BRST_CYC =
		(BRST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int WDG_TIMEOUT_MS = 100;
	localparam int WDG_CYC = WDG_TIMEOUT_MS * (CLK_HZ / 1000);
	// VME slave port states
	typedef enum logic [3:0] {
		V_IDLE = 4'h1,
		V_SLOT = 4'h2,
		V_READ = 4'h4,
		V_ACK  = 4'h8
	} vdpra_vst_t;
endpackage
`default_nettype wire

// [vdpra_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module vdpra_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // vdpra_sync
`default_nettype wire

// [vdpra_mem.sv]
// Single-port shared memory with byte enables and registered read
`timescale 1ns/1ns
`default_nettype none
module vdpra_mem #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            en,
	input  wire logic            we,
	input  wire logic [DW/8-1:0] be,
	input  wire logic [AW-1:0]   addr,
	input  wire logic [DW-1:0]   wdata,
	output var  logic [DW-1:0]   rdata
);
	logic [DW-1:0] mem [2**AW];

	// Storage kept free of reset so it maps onto plain RAM
	always_ff @(posedge pclk) begin
		if (en && we) begin
			for (int b = 0; b < DW / 8; b++) begin
				if (be[b])
					mem[addr][b*8 +: 8] <= wdata[b*8 +: 8];
			end
		end
	end

	// Read returns old data on a write cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata <= '0;
		else if (en)
			rdata <= mem[addr];
	end
endmodule // vdpra_mem
`default_nettype wire

// [vdpra_vme_host.sv]
// Behavioural VME host master that drives the slave port
`timescale 1ns/1ns
`default_nettype none
module vdpra_vme_host (
	input  wire logic        pclk,
	output var  logic        vme_as_n,
	output var  logic        vme_ds0_n,
	output var  logic        vme_ds1_n,
	output var  logic        vme_write_n,
	output var  logic [5:0]  vme_am,
	output var  logic [23:1] vme_addr,
	output var  logic [15:0] vme_data_i,
	input  wire logic [15:0] vme_data_o,
	input  wire logic        vme_data_oe,
	input  wire logic        vme_dtack_oe
);
	// Idle bus at time zero, all strobes released
	initial begin
		{vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n} = 4'hF;
		vme_am = 6'h00;
		vme_addr = '0;
		vme_data_i = 16'h5A5A;
	end
	// One transfer; strobes held until DTACK, ok low if none comes
	task automatic cycle(input logic we, input logic [5:0] am,
		input logic [23:1] a, input logic [1:0] be,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int n;
		@(posedge pclk);
		vme_am <= am;
		vme_addr <= a;
		vme_write_n <= !we;
		vme_data_i <= we ? wd : ~vme_data_i;
		vme_as_n <= 1'b0;
		vme_ds1_n <= !be[1];
		vme_ds0_n <= !be[0];
		n = 0;
		ok = 1'b0;
		while (n < 200 && !ok) begin
			@(posedge pclk);
			ok = vme_dtack_oe;
			n++;
		end
		rd = vme_data_oe ? vme_data_o : ~vme_data_o; // Undriven is wrong
		// Released lines go to their pull-up level or show the inverse
		vme_as_n <= 1'b1;
		vme_ds0_n <= 1'b1;
		vme_ds1_n <= 1'b1;
		vme_write_n <= 1'b1;
		vme_am <= 6'h3F;
		vme_data_i <= ~vme_data_i;
		vme_addr <= ~a;
		n = 0;
		while (n < 20 && vme_dtack_oe !== 1'b0) begin
			@(posedge pclk);
			n++;
		end
		ok = ok && (vme_dtack_oe === 1'b0);
	endtask
endmodule // vdpra_vme_host
`default_nettype wire

// [vdpra_top_sva.sv]
// Port-level concurrent checks of the shared-memory arbiter
`timescale 1ns/1ns
`default_nettype none
module vdpra_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic vme_as_n,
	input wire logic vme_ds0_n,
	input wire logic vme_ds1_n,
	input wire logic vme_data_oe,
	input wire logic vme_dtack_oe,
	input wire logic vme_sysreset_n,
	input wire logic vme_sysfail_oe,
	input wire logic board_reset_n,
	input wire logic pit_mbx_hs,
	input wire logic pit_tick
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Register bus answers in the first access cycle, for one cycle
	a_apb_ready_slot: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_apb_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_apb_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Board reset sources and the failure line
	a_sysreset_hold: assert property (
		(!vme_sysreset_n)[*4] |-> !board_reset_n)
		else $error("board reset not held by system reset");
	a_reset_sysfail: assert property (
		(!board_reset_n)[*3] |=> vme_sysfail_oe)
		else $error("sysfail not driven after board reset");
	a_mbx_reset_pulse: assert property (
		$fell(board_reset_n) && vme_sysreset_n |=> (!board_reset_n)[*8])
		else $error("mailbox reset pulse too short");
	// Acknowledge only for a strobe already seen through the sync
	a_dtack_cause: assert property (
		$rose(vme_dtack_oe) |-> !vme_as_n && $past(!vme_as_n, 3))
		else $error("dtack without a settled strobe");
	a_dtack_release: assert property (
		(vme_as_n && vme_ds0_n && vme_ds1_n)[*4] |-> !vme_dtack_oe)
		else $error("dtack kept after strobes released");
	a_data_ack: assert property (vme_data_oe |-> vme_dtack_oe)
		else $error("data driven without dtack");
	a_tick_pulse: assert property (pit_tick |=> !pit_tick)
		else $error("tick longer than one cycle");
	a_mbx_cause: assert property (
		$rose(pit_mbx_hs) |-> $past(!vme_as_n, 2))
		else $error("mailbox interrupt without VME access");
	c_vme_ack: cover property ($rose(vme_dtack_oe));
	c_board_rst: cover property ($fell(board_reset_n));
	c_mbx_irq: cover property ($rose(pit_mbx_hs));
endmodule // vdpra_top_sva
bind vdpra_top vdpra_top_sva i_vdpra_top_sva (.pclk, .presetn, .psel,
	.penable, .pready, .pslverr, .vme_as_n, .vme_ds0_n, .vme_ds1_n,
	.vme_data_oe, .vme_dtack_oe, .vme_sysreset_n, .vme_sysfail_oe,
	.board_reset_n, .pit_mbx_hs, .pit_tick);
`default_nettype wire

// [test_vdpra_top.sv]
// Self-checking bench of the shared-memory arbiter top
`timescale 1ns/1ns
`default_nettype none
module test_vdpra_top;
	import vdpra_pkg::*;
	localparam int WDG = 50;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        cpu_req, cpu_we, dma_req, dma_we, ok, e;
	logic [1:0]  cpu_be, dma_be;
	logic [15:0] cpu_addr, cpu_wdata, dma_addr, dma_wdata, local_rdata;
	logic        vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n;
	logic [5:0]  vme_am, jmp_am;
	logic [23:1] vme_addr;
	logic [15:0] vme_data_i, vme_data_o, vd, d;
	logic        vme_data_oe, vme_dtack_oe, vme_sysreset_n, vme_sysfail_oe;
	logic [7:1]  vme_irq_oe;
	logic [7:0]  irq_vector;
	logic [6:0]  jmp_base;
	logic [3:0]  panel_switch, module_code;
	logic        board_reset_n, pit_mbx_hs, pit_tick, wdg_fault;
	logic [15:0] mem [int];
	int          err_count = 0;
	int          num_checks = 0;
	int          lvl, n;

	vdpra_top #(.WDG_CYCLES(WDG)) i_vdpra_top (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.cpu_req, .cpu_we, .cpu_be, .cpu_addr, .cpu_wdata, .dma_req,
		.dma_we, .dma_be, .dma_addr, .dma_wdata, .local_rdata, .vme_as_n,
		.vme_ds0_n, .vme_ds1_n, .vme_write_n, .vme_am, .vme_addr,
		.vme_data_i, .vme_data_o, .vme_data_oe, .vme_dtack_oe,
		.vme_sysreset_n, .vme_sysfail_oe, .vme_irq_oe, .irq_vector,
		.jmp_base, .jmp_am, .panel_switch, .module_code, .board_reset_n,
		.pit_mbx_hs, .pit_tick, .wdg_fault);
	vdpra_vme_host i_vdpra_vme_host (.pclk, .vme_as_n, .vme_ds0_n,
		.vme_ds1_n, .vme_write_n, .vme_am, .vme_addr, .vme_data_i,
		.vme_data_o, .vme_data_oe, .vme_dtack_oe);

	// Free-running clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One register transfer; waits for pready however long it takes
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, then let registered outputs follow
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
		repeat (2) @(posedge pclk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("register read", r, exp);
		check("register error", e, 1'b0);
	endtask

	function automatic logic [31:0] stat(input logic [3:0] f);
		return {20'h0, f, module_code, panel_switch};
	endfunction

	function automatic logic [23:1] va(input logic [15:0] w);
		return {jmp_base, w};
	endfunction

	// One local access; DMA uses the inverted address and data
	task automatic loc(input logic c, m, we, input logic [15:0] a, wd);
		@(posedge pclk);
		cpu_req <= c;
		dma_req <= m;
		cpu_we <= we;
		dma_we <= we;
		cpu_addr <= a;
		dma_addr <= ~a;
		cpu_wdata <= wd;
		dma_wdata <= ~wd;
		@(posedge pclk);
		cpu_req <= 1'b0;
		dma_req <= 1'b0;
		if (we && c)
			mem[a] = wd;
		else if (we)
			mem[~a] = ~wd;
		@(posedge pclk);
		if (!we)
			check("local_rdata", local_rdata, c ? mem[a] : mem[~a]);
	endtask

	// VME transfer inside the board window, mirrored in the model
	task automatic vme(input logic we, input logic [15:0] w,
		input logic [1:0] be, input logic [15:0] wd);
		i_vdpra_vme_host.cycle(we, jmp_am, va(w), be, wd, vd, ok);
		check("vme ack", ok, 1'b1);
		if (we)
			mem[w] = {be[1] ? wd[15:8] : mem[w][15:8],
				be[0] ? wd[7:0] : mem[w][7:0]};
		else
			check("vme rdata", vd, mem[w]);
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#400_000;
		err_count++;
		final_report();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h9D867526));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
		{dma_req, dma_we, dma_addr, dma_wdata} = '0;
		{cpu_be, dma_be} = 4'hF;
		vme_sysreset_n = 1'b1;
		jmp_base = 7'($urandom);
		jmp_am = 6'($urandom);
		panel_switch = 4'($urandom);
		module_code = 4'($urandom);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		check("sysfail at reset", vme_sysfail_oe, 1'b1);
		rchk(A_CTRL, {29'h0, CTRL_RST});
		rchk(A_TICK, {8'h00, TICK_RST});
		for (int c = 0; c < IRQ_CH; c++)
			rchk(A_BIMCH0 + 12'(4 * c), {16'h0, VEC_RST, 8'h00});
		rchk(A_STAT, stat(4'h8));
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped error", e, 1'b1);
		wr(A_CTRL, 32'h1);
		check("sysfail after init", vme_sysfail_oe, 1'b0);
		wr(A_CTRL, 32'h3);
		check("sysfail on fault", vme_sysfail_oe, 1'b1);
		wr(A_CTRL, 32'h1);
		// Local traffic, then a collision in which the DMA loses
		for (int i = 0; i < 8; i++) begin
			loc(1'b1, 1'b0, 1'b1, 16'h8000 + 16'(i), 16'($urandom));
			loc(1'b0, 1'b1, 1'b1, 16'h8000 + 16'(i), 16'($urandom));
		end
		loc(1'b1, 1'b1, 1'b1, 16'h8000, 16'h1234);
		loc(1'b0, 1'b1, 1'b0, 16'h8000, 16'h0000);
		rchk(A_STAT, stat(4'h4));
		wr(A_STAT, 32'h400);
		// A VME write waits while the CPU keeps the memory busy
		fork
			vme(1'b1, 16'h0100, 2'b11, 16'hA5C3);
			begin
				@(posedge pclk);
				cpu_req <= 1'b1;
				cpu_we <= 1'b0;
				cpu_addr <= 16'h8001;
				for (int k = 0; k < 30; k++) begin
					@(posedge pclk);
					check("dtack held", vme_dtack_oe, 1'b0);
					if (k > 0)
						check("zero wait", local_rdata, mem[16'h8001]);
				end
				cpu_req <= 1'b0;
			end
		join
		// Byte lanes, word reads and the reserved low area
		vme(1'b1, 16'h0100, 2'b01, 16'h0077);
		vme(1'b1, 16'h0100, 2'b10, 16'h6600);
		vme(1'b1, 16'h0010, 2'b11, 16'($urandom));
		vme(1'b0, 16'h0100, 2'b11, 16'h0000);
		vme(1'b0, 16'h0010, 2'b11, 16'h0000);
		vme(1'b0, 16'h8001, 2'b11, 16'h0000);
		loc(1'b1, 1'b0, 1'b0, 16'h0100, 16'h0000);
		// Wrong modifier or wrong base gets no answer
		i_vdpra_vme_host.cycle(1'b1, ~jmp_am, va(16'h0200), 2'b11,
			16'h0000, vd, ok);
		check("wrong modifier", ok, 1'b0);
		i_vdpra_vme_host.cycle(1'b1, jmp_am, {~jmp_base, 16'h0200}, 2'b11,
			16'h0000, vd, ok);
		check("wrong base", ok, 1'b0);
		// Interrupt mailbox
		check("mailbox idle", pit_mbx_hs, 1'b0);
		vme(1'b1, MBX_IRQ_WADDR, 2'b11, 16'h0001);
		check("mailbox irq", pit_mbx_hs, 1'b1);
		rchk(A_STAT, stat(4'h1));
		wr(A_STAT, 32'h100);
		check("mailbox cleared", pit_mbx_hs, 1'b0);
		// Each channel at a random level with its own vector
		for (int c = 0; c < IRQ_CH; c++) begin
			lvl = $urandom_range(7, 1);
			d = 16'($urandom);
			wr(A_BIMCH0 + 12'(4 * c), {16'h0, d[7:0], 5'h0, 3'(lvl)});
			wr(A_BIMCTL, 32'(1 << c));
			check("irq level", vme_irq_oe, 7'(1 << (lvl - 1)));
			check("irq vector", irq_vector, d[7:0]);
			rchk(A_BIMCTL, 32'(1 << c));
			wr(A_BIMCTL, 32'(16 << c));
			check("irq cleared", vme_irq_oe, 7'h00);
		end
		// Tick period measured between two pulses
		wr(A_TICK, 32'h14);
		do @(posedge pclk); while (pit_tick !== 1'b1);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pit_tick !== 1'b1 && n < 100);
		check("tick period", n, 32'h14);
		// Watchdog fires with no local activity
		check("watchdog quiet", wdg_fault, 1'b0);
		wr(A_CTRL, 32'h5);
		repeat (WDG + 5) @(posedge pclk);
		check("watchdog fault", wdg_fault, 1'b1);
		rchk(A_STAT, stat(4'h2));
		// System reset from the backplane
		@(posedge pclk);
		vme_sysreset_n <= 1'b0;
		repeat (6) @(posedge pclk);
		check("sysreset holds board", board_reset_n, 1'b0);
		vme_sysreset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		rchk(A_CTRL, 32'h0);
		check("sysfail after sysreset", vme_sysfail_oe, 1'b1);
		// Reset mailbox; the access itself still completes
		wr(A_CTRL, 32'h1);
		vme(1'b1, MBX_RESET_WADDR, 2'b11, 16'h0000);
		check("mailbox reset", board_reset_n, 1'b0);
		repeat (40) @(posedge pclk);
		rchk(A_CTRL, 32'h0);
		check("sysfail after mailbox", vme_sysfail_oe, 1'b1);
		final_report();
	end
endmodule // test_vdpra_top
`default_nettype wire
